// file: rtl/refresh_pkg.sv
package refresh_pkg;

  localparam int INTERVAL_W = 10;
  localparam int BASE_W = 12;
  localparam int LFSR_W = 7;
  localparam int ROW_W = 6;
  localparam int ADDR_W = 25;

  localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 10'h000;
  localparam logic [INTERVAL_W-1:0] INTERVAL_ONE = 10'h001;
  localparam logic [BASE_W-1:0] BASE_RESET = 12'h000;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 7'h7F;
  localparam logic [ROW_W-1:0] ROW_RESET = 6'h00;
  localparam logic [ROW_W-1:0] ROW_ONE = 6'h01;
  localparam int LFSR_TAP_HI = 6;
  localparam int LFSR_TAP_LO = 5;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_CYCLE = 2'b10
  } refresh_state_e;

  typedef enum logic [1:0] {
    OWN_CPU = 2'b00,
    OWN_DMA = 2'b01,
    OWN_EXT = 2'b10,
    OWN_RFSH = 2'b11
  } bus_owner_e;

  typedef struct packed {
    logic enable;
    logic wr_interval;
    logic [INTERVAL_W-1:0] interval;
    logic wr_base;
    logic [BASE_W-1:0] base;
    logic powerdown;
  } refresh_cfg_s;

  typedef struct packed {
    logic dma_req;
    logic dma_active;
    logic hold_req;
    logic cpu_cycle_busy;
    logic cycle_done;
  } bus_in_s;

  typedef struct packed {
    refresh_state_e state;
    logic [INTERVAL_W-1:0] count;
    logic proc_clk_d;
    logic timeout;
    logic pending;
    logic [LFSR_W-1:0] lfsr;
    logic [ROW_W-1:0] row;
    logic [BASE_W-1:0] base;
    logic [INTERVAL_W-1:0] interval;
    logic enable;
    logic refresh_n;
    logic mem_read;
    logic [ADDR_W-1:0] addr;
    logic low_byte_strobe_n;
    logic high_byte_strobe_n;
    logic dma_grant;
    logic hold_ack;
    logic ext_return;
  } refresh_state_s;

endpackage : refresh_pkg

// file: rtl/dram_refresh_request_unit.sv
// Behaviour
// - Ten-bit interval counter decrements on falling edges
// - At one, reload counter and pulse timeout
// - Timeout raises request unless one is pending
// - Address upper bits from base register
// - LFSR gives low seven, counter upper six
// - LFSR visits all 128; counter steps per pass
// - Whole 8192 sequence rolls over and repeats
// - Once granted, strobe low and memory read
// - Cycle end drops strobe, await next timeout
// - Refresh outranks DMA and external hold
// - Refresh steals one cycle from DMA
// - Refresh withdraws external master's acknowledge
// - Reasserted hold regains bus without arbitration
// - Refresh runs until reprogram, reset, powerdown
// - Strobe low only during refresh cycle
// - Control bit fifteen enables whole unit
// - Counter value readable, writes ignored
// - Both byte strobes high during refresh
`timescale 1ns/1ps
`default_nettype none

module dram_refresh_request_unit (
  input wire logic ref_clk, // 100 MHz system clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic processor_clock, // Processor clock, divided domain
  input wire refresh_pkg::refresh_cfg_s cfg, // Register writes and enable
  input wire refresh_pkg::bus_in_s bus_in, // Bus arbitration requests
  output logic refresh_n, // Refresh strobe, active low
  output logic mem_read, // Refresh memory read cycle
  output logic [refresh_pkg::ADDR_W-1:0] refresh_addr, // A25:1
  output logic low_byte_strobe_n, // Low byte strobe, active low
  output logic high_byte_strobe_n, // High byte strobe, active low
  output logic dma_grant, // DMA may run next cycle
  output logic hold_ack, // External master acknowledge
  output logic [refresh_pkg::INTERVAL_W-1:0] count_value, // Live counter
  output logic [refresh_pkg::LFSR_W+refresh_pkg::ROW_W-1:0] row_addr // A13:1
);

  refresh_pkg::refresh_state_s s_reg;
  refresh_pkg::refresh_state_s s_next;
  logic pclk_s1;
  logic pclk_s2;

  // Processor clock comes from another domain
  always_ff @(posedge ref_clk) begin
    pclk_s1 <= processor_clock;
    pclk_s2 <= pclk_s1;
  end

  function automatic logic [refresh_pkg::LFSR_W-1:0] lfsr_step(
    input logic [refresh_pkg::LFSR_W-1:0] v
  );
    // x^7+x^6+1 maximal; extra term lets all-zero join the ring
    logic fb;
    logic rest_zero;
    // Only bits that stay in the register may be tested, or the ring splits
    rest_zero = (v[refresh_pkg::LFSR_W-2:0] == '0);
    fb = v[refresh_pkg::LFSR_TAP_HI] ^ v[refresh_pkg::LFSR_TAP_LO] ^ rest_zero;
    lfsr_step = {v[refresh_pkg::LFSR_W-2:0], fb};
  endfunction : lfsr_step

  // A pending request only counts while the unit runs
  function automatic logic want_bus(
    input logic pend,
    input logic act
  );
    want_bus = pend & act;
  endfunction : want_bus

  always_comb begin
    logic fall;
    logic active;
    logic [refresh_pkg::LFSR_W-1:0] nl;
    fall = 1'b0;
    active = 1'b0;
    nl = '0;
    s_next = s_reg;
    s_next.proc_clk_d = pclk_s2;
    fall = s_reg.proc_clk_d & ~pclk_s2;
    s_next.timeout = 1'b0;

    if (cfg.wr_interval) begin
      s_next.interval = cfg.interval;
      s_next.count = cfg.interval;
    end
    if (cfg.wr_base) begin
      s_next.base = cfg.base;
    end
    s_next.enable = cfg.enable & ~cfg.powerdown;
    active = s_reg.enable;

    if (!active) begin
      // Disabled or powered down: stop and forget any request
      s_next.pending = 1'b0;
      s_next.state = refresh_pkg::ST_IDLE;
      s_next.refresh_n = 1'b1;
      s_next.mem_read = 1'b0;
      // Reload so a re-enable starts a full period
      s_next.count = cfg.wr_interval ? cfg.interval : s_reg.interval;
    end else if (fall && !cfg.wr_interval) begin
      // Zero counts as expiry so a blank interval cannot stall refresh
      if (s_reg.count <= refresh_pkg::INTERVAL_ONE) begin
        s_next.count = s_reg.interval;
        s_next.timeout = 1'b1;
      end else begin
        s_next.count = s_reg.count - refresh_pkg::INTERVAL_ONE;
      end
    end

    if (s_reg.timeout && active && !s_reg.pending) begin
      s_next.pending = 1'b1;
    end

    case (s_reg.state)
      refresh_pkg::ST_IDLE: begin
        if (want_bus(s_reg.pending, active)) begin
          s_next.state = refresh_pkg::ST_REQ;
        end
      end
      refresh_pkg::ST_REQ: begin
        // Wait for CPU cycle and external master to let go
        if (!active) begin
          s_next.state = refresh_pkg::ST_IDLE;
        end else if (!bus_in.cpu_cycle_busy && !s_reg.hold_ack) begin
          s_next.state = refresh_pkg::ST_CYCLE;
          s_next.refresh_n = 1'b0;
          s_next.mem_read = 1'b1;
        end
      end
      refresh_pkg::ST_CYCLE: begin
        if (bus_in.cycle_done || !active) begin
          s_next.state = refresh_pkg::ST_IDLE;
          s_next.refresh_n = 1'b1;
          s_next.mem_read = 1'b0;
          s_next.pending = 1'b0;
          // Also steps on abort, so the next refresh never repeats a row
          nl = lfsr_step(s_reg.lfsr);
          s_next.lfsr = nl;
          if (nl == refresh_pkg::LFSR_SEED) begin
            s_next.row = s_reg.row + refresh_pkg::ROW_ONE;
          end
        end
      end
      default: s_next.state = refresh_pkg::ST_IDLE;
    endcase

    // Registered each clock, so it trails the counter by one
    s_next.addr = {s_reg.base, s_reg.row, s_reg.lfsr};
    s_next.low_byte_strobe_n = 1'b1;
    s_next.high_byte_strobe_n = 1'b1;

    // Arbitration: refresh first, then a reclaimed hold, then DMA and hold
    if (s_reg.state != refresh_pkg::ST_IDLE || want_bus(s_reg.pending, active)) begin
      s_next.dma_grant = 1'b0;
      if (s_reg.hold_ack) begin
        s_next.hold_ack = 1'b0;
        s_next.ext_return = 1'b0;
      end else if (bus_in.hold_req && s_reg.state == refresh_pkg::ST_CYCLE) begin
        s_next.ext_return = 1'b1;
      end else if (!bus_in.hold_req) begin
        s_next.ext_return = 1'b0;
      end
    end else if (s_reg.ext_return && bus_in.hold_req) begin
      // Reclaimed hold skips a fresh arbitration round
      s_next.hold_ack = 1'b1;
      s_next.ext_return = 1'b0;
      s_next.dma_grant = 1'b0;
    end else begin
      // An active DMA blocks a new hold; a hold owner keeps the bus
      s_next.ext_return = 1'b0;
      s_next.dma_grant = bus_in.dma_req & ~s_reg.hold_ack;
      s_next.hold_ack = bus_in.hold_req & (s_reg.hold_ack | ~bus_in.dma_active);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_reg <= '{
        state: refresh_pkg::ST_IDLE,
        count: refresh_pkg::INTERVAL_RESET,
        proc_clk_d: 1'b0,
        timeout: 1'b0,
        pending: 1'b0,
        lfsr: refresh_pkg::LFSR_SEED,
        row: refresh_pkg::ROW_RESET,
        base: refresh_pkg::BASE_RESET,
        interval: refresh_pkg::INTERVAL_RESET,
        enable: 1'b0,
        refresh_n: 1'b1,
        mem_read: 1'b0,
        addr: '0,
        low_byte_strobe_n: 1'b1,
        high_byte_strobe_n: 1'b1,
        dma_grant: 1'b0,
        hold_ack: 1'b0,
        ext_return: 1'b0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  assign refresh_n = s_reg.refresh_n;
  assign mem_read = s_reg.mem_read;
  assign refresh_addr = s_reg.addr;
  assign low_byte_strobe_n = s_reg.low_byte_strobe_n;
  assign high_byte_strobe_n = s_reg.high_byte_strobe_n;
  assign dma_grant = s_reg.dma_grant;
  assign hold_ack = s_reg.hold_ack;
  assign count_value = s_reg.count;
  assign row_addr = {s_reg.row, s_reg.lfsr};

endmodule : dram_refresh_request_unit

`default_nettype wire

// file: tb/refresh_props.sv
`timescale 1ns/1ps
`default_nettype none
module refresh_props (
  input wire logic ref_clk, // Clock
  input wire logic srst, // Reset
  input wire refresh_pkg::refresh_cfg_s cfg, // Config
  input wire refresh_pkg::bus_in_s bus_in, // Bus inputs
  input wire logic refresh_n, // Strobe
  input wire logic mem_read, // Read
  input wire logic [refresh_pkg::ADDR_W-1:0] refresh_addr, // Address
  input wire logic low_byte_strobe_n, // Low lane
  input wire logic high_byte_strobe_n, // High lane
  input wire logic dma_grant, // DMA grant
  input wire logic hold_ack, // Hold ack
  input wire logic [refresh_pkg::INTERVAL_W-1:0] count_value, // Counter
  input wire logic [refresh_pkg::LFSR_W+refresh_pkg::ROW_W-1:0] row_addr // Row
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_live; !refresh_n; endsequence
  sequence s_end; $rose(refresh_n); endsequence
  a_strobe_read: assert property (mem_read == !refresh_n)
    else $error("strobe and read differ");
  a_lanes_high: assert property (s_live |-> low_byte_strobe_n && high_byte_strobe_n)
    else $error("byte lane low in refresh");
  a_bus_taken: assert property (s_live |-> !hold_ack && !dma_grant)
    else $error("other master granted");
  a_row_addr: assert property (s_live |-> refresh_addr[12:0] == row_addr)
    else $error("row bits wrong");
  a_cycle_end: assert property (bus_in.cycle_done && !refresh_n |=> refresh_n)
    else $error("strobe held past end");
  a_off_quiet: assert property ((!cfg.enable || cfg.powerdown) [*4] |-> refresh_n)
    else $error("strobe while off");
  a_count_step: assert property (count_value != $past(count_value) && !$past(cfg.wr_interval)
    && $past(cfg.enable, 2) && !$past(cfg.powerdown, 2)
    |-> count_value == $past(count_value) - 10'h001 || $past(count_value) <= 10'h001)
    else $error("counter jumped");
  a_row_steps: assert property ($rose(refresh_n) && $past(bus_in.cycle_done)
    |-> row_addr != $past(row_addr))
    else $error("row did not step");
  a_hold_back: assert property (s_end ##0 (bus_in.hold_req && $past(bus_in.hold_req))
    |-> ##[0:2] hold_ack)
    else $error("hold not returned");
endmodule : refresh_props
bind dram_refresh_request_unit refresh_props i_props (.ref_clk, .srst, .cfg, .bus_in,
  .refresh_n, .mem_read, .refresh_addr, .low_byte_strobe_n, .high_byte_strobe_n,
  .dma_grant, .hold_ack, .count_value, .row_addr);
`default_nettype wire

// file: tb/dram_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dram_ctrl_model (
  input wire logic ref_clk, // Clock
  input wire logic srst, // Reset
  input wire logic refresh_n, // Strobe
  input wire logic slow, // Long cycle
  input wire logic cbr, // Column first
  output logic cycle_done, // Read ends
  output logic ras_n, // Row strobe, active low
  output logic cas_n // Column strobe, active low
);
  logic [2:0] wait_reg;
  always_ff @(posedge ref_clk) begin
    if (srst || refresh_n) wait_reg <= 3'h0;
    else if (wait_reg != 3'h7) wait_reg <= wait_reg + 3'h1;
  end
  assign cycle_done = !refresh_n && wait_reg == (slow ? 3'h5 : 3'h2);
  // With cbr set, column strobe leads row strobe by one cycle
  assign cas_n = !(cbr && !refresh_n);
  assign ras_n = !(!refresh_n && (!cbr || wait_reg != 3'h0));
endmodule : dram_ctrl_model
`default_nettype wire

// file: tb/dram_refresh_request_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dram_refresh_request_unit_tb;
  logic ref_clk = 0;
  logic srst = 1;
  logic [1:0] pdiv = 2'h0;
  logic dma_req = 0, dma_act = 0, hold_req = 0, slow = 0, cbr = 0, cpu_busy = 0;
  logic cycle_done, refresh_n, mem_read, lo_n, hi_n, dma_grant, hold_ack, ras_n, cas_n;
  refresh_pkg::refresh_cfg_s cfg = '0;
  refresh_pkg::bus_in_s bus_in;
  logic [refresh_pkg::ADDR_W-1:0] addr;
  logic [9:0] cnt;
  logic [12:0] row;
  logic seen [128];
  int n_fail = 0;
  int checks = 0;
  assign bus_in = '{dma_req, dma_act, hold_req, cpu_busy, cycle_done};
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) pdiv <= #1 pdiv + 2'h1;
  dram_refresh_request_unit i_dut (.ref_clk(ref_clk), .srst(srst),
    .processor_clock(pdiv[1]), .cfg(cfg), .bus_in(bus_in), .refresh_n(refresh_n),
    .mem_read(mem_read), .refresh_addr(addr), .low_byte_strobe_n(lo_n),
    .high_byte_strobe_n(hi_n), .dma_grant(dma_grant), .hold_ack(hold_ack),
    .count_value(cnt), .row_addr(row));
  dram_ctrl_model i_mem (.ref_clk(ref_clk), .srst(srst), .refresh_n(refresh_n),
    .slow(slow), .cbr(cbr), .cycle_done(cycle_done), .ras_n(ras_n), .cas_n(cas_n));
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wait_lvl(input logic v);
    for (int i = 0; i < 400 && refresh_n !== v; i++) step(1);
    chk(refresh_n === v, "strobe wait");
  endtask : wait_lvl
  task automatic give_verdict();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic t_setup();
    chk(refresh_n === 1'b1 && cnt === 10'h000 && hold_ack === 1'b0, "reset");
    cfg = '{wr_interval: 1, interval: 10'h003, wr_base: 1, base: 12'hA5C, default: 0};
    step(1);
    cfg = '{enable: 1, interval: 10'h003, base: 12'hA5C, default: 0};
    chk(cnt === 10'h003, "interval load");
    wait_lvl(1'b0);
    chk(addr[24:13] === 12'hA5C, "base bits");
    chk(lo_n === 1'b1 && hi_n === 1'b1, "lanes");
    chk(ras_n === 1'b0 && cas_n === 1'b1, "row strobe only");
    wait_lvl(1'b1);
  endtask : t_setup
  task automatic t_busy();
    logic bad;
    bad = 0;
    cpu_busy = 1;
    for (int i = 0; i < 30; i++) begin
      bad |= refresh_n !== 1'b1;
      step(1);
    end
    chk(!bad, "refresh during cpu cycle");
    cpu_busy = 0;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
  endtask : t_busy
  task automatic t_hold();
    hold_req = 1;
    wait_lvl(1'b0);
    chk(hold_ack === 1'b0, "hold not withdrawn");
    hold_req = 0;
    step(1);
    hold_req = 1;
    wait_lvl(1'b1);
    step(3);
    chk(hold_ack === 1'b1, "hold back");
    hold_req = 0;
  endtask : t_hold
  task automatic t_dma();
    {dma_req, dma_act, slow} = 3'h7;
    wait_lvl(1'b0);
    chk(dma_grant === 1'b0, "dma stolen");
    wait_lvl(1'b1);
    step(2);
    chk(dma_grant === 1'b1, "dma resumes");
    {dma_req, dma_act, slow} = 3'h0;
  endtask : t_dma
  task automatic t_lfsr();
    logic dup;
    dup = 0;
    srst = 1;
    cbr = 1;
    step(2);
    srst = 0;
    // Fresh start so the sequence begins at the seed
    for (int k = 0; k < 128; k++) begin
      wait_lvl(1'b0);
      dup |= seen[addr[6:0]] === 1'b1;
      seen[addr[6:0]] = 1;
      if (k == 0) begin
        chk(cas_n === 1'b0 && ras_n === 1'b1, "column strobe first");
        step(1);
        chk(cas_n === 1'b0 && ras_n === 1'b0, "row strobe follows");
      end
      wait_lvl(1'b1);
    end
    step(1);
    chk(!dup, "lfsr repeat");
    chk(row === 13'h00FF, "row wrap");
  endtask : t_lfsr
  task automatic t_off();
    logic bad;
    for (int m = 0; m < 2; m++) begin
      bad = 0;
      {cfg.enable, cfg.powerdown} = {m[0], m[0]};
      step(4);
      for (int i = 0; i < 60; i++) begin
        bad |= refresh_n !== 1'b1;
        step(1);
      end
      chk(!bad, "refresh while off");
    end
  endtask : t_off
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
  initial begin
    step(20);
    srst = 0;
    t_setup();
    t_busy();
    t_hold();
    t_dma();
    t_lfsr();
    t_off();
    give_verdict();
  end
endmodule : dram_refresh_request_unit_tb
`default_nettype wire
